// ### core/adc_channel_and_reference_control.sv
// channel select, start/done handshake, enable and reference control
//
// Decided for this implementation: the register offsets and strobed register access.
module adc_channel_and_reference_control #(
    parameter int       TICK_DIV     = adc_ctrl_pkg::TICK_DIV,
    parameter int       SAMPLE_TICKS = adc_ctrl_pkg::SAMPLE_TICKS,
    parameter bit       REDUCED_PINS = 1'b0
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic [2:0]         addr,
    input  wire logic [7:0]         wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic      [7:0]         rd_data,
    input  wire logic               compare_above,
    output logic                    converter_power,
    output logic      [12:0]        analog_input_select,
    output logic                    fixed_ref_select,
    output logic                    low_ref_from_pin,
    output logic                    high_ref_from_pin,
    output logic                    sample_hold,
    output logic      [9:0]         trial_code
);
    localparam int DIV_W = $clog2(TICK_DIV + 1);
    localparam int SMP_W = $clog2(SAMPLE_TICKS + 1);

    // register state
    logic [3:0]                     input_channel_select;
    logic                           converter_enable;
    logic                           conv_status;
    logic                           negative_reference_select;
    logic                           positive_reference_select;
    logic                           result_format_select;
    logic [9:0]                     result;

    // sequencer state
    adc_ctrl_pkg::conv_state_e      state;
    adc_ctrl_pkg::conv_state_e      next_state;
    logic [DIV_W-1:0]               div_cnt;
    logic [SMP_W-1:0]               smp_cnt;
    logic [3:0]                     bit_idx;
    logic [9:0]                     next_trial;

    // comparator synchroniser
    logic                           cmp_s1;
    logic                           cmp_s2;
    logic                           cmp_s3;
    logic                           cmp_level;

    // bus decode
    wire sel_control   = (addr == adc_ctrl_pkg::OFF_CONTROL);
    wire sel_reference = (addr == adc_ctrl_pkg::OFF_REFERENCE);
    wire sel_format    = (addr == adc_ctrl_pkg::OFF_FORMAT);
    wire sel_res_high  = (addr == adc_ctrl_pkg::OFF_RESULT_HIGH);
    wire sel_res_low   = (addr == adc_ctrl_pkg::OFF_RESULT_LOW);
    wire wr_control    = wr_en && sel_control;
    wire wr_reference  = wr_en && sel_reference;
    wire wr_format     = wr_en && sel_format;

    wire wr_start  = wr_control && wr_data[adc_ctrl_pkg::POS_STATUS];
    wire wr_enable = wr_data[adc_ctrl_pkg::POS_ENABLE];
    // a start with the converter left off is ignored: nothing to run on
    wire start_req = wr_start && wr_enable;
    // software writing zero mid-conversion, or power off, aborts it
    wire abort_req = (wr_control && !wr_data[adc_ctrl_pkg::POS_STATUS])
                     || !converter_enable;

    // conversion clock enable
    wire tick = (div_cnt == DIV_W'(TICK_DIV - 1));
    wire smp_done = (smp_cnt == SMP_W'(SAMPLE_TICKS - 1));
    wire last_bit = (bit_idx == 4'h0);
    wire finish = (state == adc_ctrl_pkg::ST_CONVERT) && tick && last_bit;

    // successive approximation step: keep or drop the bit under trial
    wire [9:0] bit_mask = 10'h001 << bit_idx;
    wire [9:0] decided  = cmp_level ? trial_code : (trial_code & ~bit_mask);
    wire [9:0] lower_bit = bit_mask >> 1;

    // result byte views
    wire [7:0] res_high = result_format_select
                          ? {6'h00, result[9:8]}
                          : result[9:2];
    wire [7:0] res_low  = result_format_select
                          ? result[7:0]
                          : {result[1:0], 6'h00};

    wire [7:0] control_view = {2'h0,
                               input_channel_select,
                               conv_status,
                               converter_enable};
    wire [7:0] reference_view = {2'h0,
                                 negative_reference_select,
                                 positive_reference_select,
                                 4'h0};
    wire [7:0] format_view = {result_format_select, 7'h00};

    wire [7:0] read_mux = sel_control   ? control_view   :
                          sel_reference ? reference_view :
                          sel_format    ? format_view    :
                          sel_res_high  ? res_high       :
                          sel_res_low   ? res_low        :
                          adc_ctrl_pkg::RST_DATA;

    // channel decode
    wire optional_code = (input_channel_select >= adc_ctrl_pkg::CH_OPT_FIRST)
                      && (input_channel_select <= adc_ctrl_pkg::CH_OPT_LAST);
    wire code_blocked  = REDUCED_PINS && optional_code;
    wire code_is_input = (input_channel_select <= adc_ctrl_pkg::CH_LAST_INPUT)
                         && !code_blocked;
    wire [12:0] next_input_select = code_is_input
                                    ? (13'h0001 << input_channel_select)
                                    : 13'h0000;
    // acquisition time for this channel is left to software
    wire next_fixed_ref = (input_channel_select
                           == adc_ctrl_pkg::CH_FIXED_REF);

    // register writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            input_channel_select <= adc_ctrl_pkg::RST_CHANNEL;
            converter_enable     <= 1'b0;
        end else if (wr_control) begin
            input_channel_select <= wr_data[adc_ctrl_pkg::POS_CHANNEL_LO +:
                                            adc_ctrl_pkg::CHANNEL_W];
            converter_enable     <= wr_enable;
        end
    end

    // only bits 5 and 4 hold anything here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            negative_reference_select <= 1'b0;
            positive_reference_select <= 1'b0;
        end else if (wr_reference) begin
            negative_reference_select <=
                wr_data[adc_ctrl_pkg::POS_NEG_REF];
            positive_reference_select <=
                wr_data[adc_ctrl_pkg::POS_POS_REF];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_format_select <= 1'b0;
        end else if (wr_format) begin
            result_format_select <= wr_data[adc_ctrl_pkg::POS_FORMAT];
        end
    end

    // status bit: a new start wins over the clear at completion
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conv_status <= 1'b0;
        end else if (start_req) begin
            conv_status <= 1'b1;
        end else if (finish || abort_req) begin
            conv_status <= 1'b0;
        end
    end

    // comparator crosses in from the analog side
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            cmp_s3 <= 1'b0;
        end else begin
            cmp_s1 <= compare_above;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmp_level <= 1'b0;
        end else if (cmp_s2 == cmp_s3) begin
            cmp_level <= cmp_s3;
        end
    end

    // sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            adc_ctrl_pkg::ST_IDLE: begin
                if (start_req) begin
                    next_state = adc_ctrl_pkg::ST_SAMPLE;
                end
            end
            adc_ctrl_pkg::ST_SAMPLE: begin
                // a restart must not slip into convert on a stale tick
                if (start_req) begin
                    next_state = adc_ctrl_pkg::ST_SAMPLE;
                end else if (abort_req) begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                end else if (tick && smp_done) begin
                    next_state = adc_ctrl_pkg::ST_CONVERT;
                end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
                if (start_req) begin
                    next_state = adc_ctrl_pkg::ST_SAMPLE;
                end else if (abort_req || finish) begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= adc_ctrl_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // divider runs only while busy, so a conversion starts on a fresh tick
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (state == adc_ctrl_pkg::ST_IDLE || start_req || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            smp_cnt <= '0;
        end else if (state != adc_ctrl_pkg::ST_SAMPLE || start_req) begin
            smp_cnt <= '0;
        end else if (tick) begin
            smp_cnt <= smp_cnt + SMP_W'(1);
        end
    end

    // trial code walks from the top bit down
    always_comb begin
        next_trial = trial_code;
        if (start_req) begin
            next_trial = 10'h200;
        end else if (state == adc_ctrl_pkg::ST_CONVERT && tick) begin
            next_trial = decided | lower_bit;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trial_code <= adc_ctrl_pkg::RST_RESULT;
            bit_idx    <= 4'h0;
        end else begin
            trial_code <= next_trial;
            if (start_req) begin
                bit_idx <= 4'(adc_ctrl_pkg::RESULT_W - 1);
            end else if (state == adc_ctrl_pkg::ST_CONVERT && tick
                         && !last_bit) begin
                bit_idx <= bit_idx - 4'h1;
            end
        end
    end

    // result lands on the same edge that clears the status bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result <= adc_ctrl_pkg::RST_RESULT;
        end else if (finish && !abort_req) begin
            result <= decided;
        end
    end

    // analog-facing outputs, each its own flop, one cycle behind the regs; sample_hold decodes next_state, so it is level with state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            converter_power <= 1'b0;
        end else begin
            converter_power <= converter_enable;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            analog_input_select <= 13'h0000;
        end else begin
            analog_input_select <= next_input_select;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fixed_ref_select <= 1'b0;
        end else begin
            fixed_ref_select <= next_fixed_ref;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_ref_from_pin <= 1'b0;
        end else begin
            low_ref_from_pin <= negative_reference_select;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            high_ref_from_pin <= 1'b0;
        end else begin
            high_ref_from_pin <= positive_reference_select;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_hold <= 1'b0;
        end else begin
            sample_hold <= (next_state == adc_ctrl_pkg::ST_SAMPLE);
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data <= adc_ctrl_pkg::RST_DATA;
        end else if (rd_en) begin
            rd_data <= read_mux;
        end else begin
            rd_data <= adc_ctrl_pkg::RST_DATA;
        end
    end
endmodule

// ### core/adc_ctrl_pkg.sv
// constants for the converter channel and reference control block
package adc_ctrl_pkg;
    localparam int          ADDR_W           = 3;
    localparam int          DATA_W           = 8;
    localparam int          RESULT_W         = 10;
    localparam int          NUM_INPUTS       = 13;

    // register offsets
    localparam logic [2:0]  OFF_CONTROL      = 3'h0;
    localparam logic [2:0]  OFF_REFERENCE    = 3'h1;
    localparam logic [2:0]  OFF_FORMAT       = 3'h2;
    localparam logic [2:0]  OFF_RESULT_HIGH  = 3'h3;
    localparam logic [2:0]  OFF_RESULT_LOW   = 3'h4;

    // control register fields
    localparam int          POS_ENABLE       = 0;
    localparam int          POS_STATUS       = 1;
    localparam int          POS_CHANNEL_LO   = 2;
    localparam int          CHANNEL_W        = 4;
    // reference register fields
    localparam int          POS_POS_REF      = 4;
    localparam int          POS_NEG_REF      = 5;
    // format register field
    localparam int          POS_FORMAT       = 7;

    // reset values
    localparam logic [3:0]  RST_CHANNEL      = 4'h0;
    localparam logic [7:0]  RST_DATA         = 8'h00;
    localparam logic [9:0]  RST_RESULT       = 10'h000;

    // channel codes
    localparam logic [3:0]  CH_LAST_INPUT    = 4'hC;
    localparam logic [3:0]  CH_FIXED_REF     = 4'hF;
    localparam logic [3:0]  CH_OPT_FIRST     = 4'h5;
    localparam logic [3:0]  CH_OPT_LAST      = 4'h7;

    // cycle counts
    localparam int          CLK_MHZ          = 100;
    localparam int          TICK_DIV         = 4;
    localparam int          SAMPLE_TICKS     = 2;
    // advisory settle for the fixed reference channel, in us
    localparam int          FIXED_REF_ACQ_US = 15;
    localparam int          FIXED_REF_ACQ_CYC = FIXED_REF_ACQ_US * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } conv_state_e;
endpackage

// ### bench/adc_ctrl_asserts.sv
// port assertions for the converter channel and reference control block
module adc_ctrl_asserts #(
    parameter int TICK_DIV     = 4,
    parameter int SAMPLE_TICKS = 2,
    parameter bit REDUCED_PINS = 1'b0
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [2:0]  addr,
    input wire logic [7:0]  wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  rd_data,
    input wire logic        compare_above,
    input wire logic        converter_power,
    input wire logic [12:0] analog_input_select,
    input wire logic        fixed_ref_select,
    input wire logic        low_ref_from_pin,
    input wire logic        high_ref_from_pin,
    input wire logic        sample_hold,
    input wire logic [9:0]  trial_code
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire       ctl_wr = wr_en && addr == 3'h0;
    wire       ref_wr = wr_en && addr == 3'h1;
    wire       start  = ctl_wr && wr_data[1:0] == 2'h3;
    wire [3:0] code   = wr_data[5:2];
    // optional codes are blocked on the reduced variant
    wire       opt    = REDUCED_PINS && code >= 4'h5 && code <= 4'h7;
    wire       short_sample = SAMPLE_TICKS * TICK_DIV == 8;

    property p_unused_zero;
        rd_en && addr == 3'h1 |=> rd_data[7:6] == 2'h0 && rd_data[3:0] == 4'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("spare bits set");
    // pins sit two flops behind a register write
    property p_power;
        ctl_wr |-> ##2 converter_power == $past(wr_data[0], 2);
    endproperty
    a_power: assert property (p_power)
        else $error("power wrong");
    property p_neg_ref;
        ref_wr |-> ##2 low_ref_from_pin == $past(wr_data[5], 2);
    endproperty
    a_neg_ref: assert property (p_neg_ref)
        else $error("low ref wrong");
    property p_pos_ref;
        ref_wr |-> ##2 high_ref_from_pin == $past(wr_data[4], 2);
    endproperty
    a_pos_ref: assert property (p_pos_ref)
        else $error("high ref wrong");
    property p_fixed;
        ctl_wr && code == 4'hF
            |-> ##2 fixed_ref_select && analog_input_select == 13'h0000;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed ref wrong");
    property p_reserved;
        ctl_wr && (code == 4'hD || code == 4'hE)
            |-> ##2 !fixed_ref_select && analog_input_select == 13'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved hit");
    property p_chan;
        ctl_wr && code <= 4'hC && !opt
            |-> ##2 analog_input_select == 13'h0001 << $past(code, 2);
    endproperty
    a_chan: assert property (p_chan)
        else $error("input wrong");
    // power follows one edge later than the sequencer outputs
    property p_start;
        start |=> sample_hold && trial_code == 10'h200 ##1 converter_power;
    endproperty
    a_start: assert property (p_start)
        else $error("no start");
    property p_sample;
        short_sample && start ##1 (!ctl_wr && sample_hold)[*8] |=> !sample_hold;
    endproperty
    a_sample: assert property (p_sample)
        else $error("sample length");
endmodule

bind adc_channel_and_reference_control adc_ctrl_asserts #(
    .TICK_DIV(TICK_DIV), .SAMPLE_TICKS(SAMPLE_TICKS),
    .REDUCED_PINS(REDUCED_PINS)
) u_chk (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .compare_above(compare_above), .converter_power(converter_power),
    .analog_input_select(analog_input_select),
    .fixed_ref_select(fixed_ref_select), .low_ref_from_pin(low_ref_from_pin),
    .high_ref_from_pin(high_ref_from_pin), .sample_hold(sample_hold),
    .trial_code(trial_code)
);

// ### bench/test_adc_channel_and_reference_control.sv
// self-checking bench for the converter channel and reference control block
module test_adc_channel_and_reference_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk      = 1'b0;
    logic        rst           = 1'b1;
    logic [2:0]  addr          = 3'h0;
    logic [7:0]  wr_data       = 8'h00;
    logic        wr_en         = 1'b0;
    logic        rd_en         = 1'b0;
    logic        compare_above = 1'b0;
    logic [7:0]  rd_data;
    logic        converter_power;
    logic [12:0] analog_input_select;
    logic        fixed_ref_select;
    logic        low_ref_from_pin;
    logic        high_ref_from_pin;
    logic        sample_hold;
    logic [9:0]  trial_code;
    logic [7:0]  d;
    int          n_mismatch    = 0;
    int          checks_done   = 0;

    adc_channel_and_reference_control i_dut (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .compare_above(compare_above), .converter_power(converter_power),
        .analog_input_select(analog_input_select),
        .fixed_ref_select(fixed_ref_select),
        .low_ref_from_pin(low_ref_from_pin),
        .high_ref_from_pin(high_ref_from_pin), .sample_hold(sample_hold),
        .trial_code(trial_code)
    );

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // registered outputs: one extra edge before looking
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset();
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0]);
            chk(d, 8'h00);
        end
        wr(3'h5, 8'hFF);
        rd(3'h5);
        chk(d, 8'h00);
    endtask

    task automatic t_refs();
        logic [7:0] tab [4] = '{8'hFF, 8'h10, 8'h20, 8'h00};
        foreach (tab[i]) begin
            wr(3'h1, tab[i]);
            settle();
            chk(low_ref_from_pin, tab[i][5]);
            chk(high_ref_from_pin, tab[i][4]);
            rd(3'h1);
            chk(d, tab[i] & 8'h30);
        end
    endtask

    task automatic t_channels();
        logic [3:0] c;
        logic [12:0] exp_sel;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            exp_sel = (c <= 4'hC) ? (13'h0001 << c) : 13'h0000;
            wr(3'h0, 8'hC0 | {2'h0, c, 2'h0});
            settle();
            chk(analog_input_select, exp_sel);
            chk(fixed_ref_select, c == 4'hF);
            rd(3'h0);
            chk(d, {2'h0, c, 2'h0});
        end
    endtask

    task automatic t_convert(input logic cmp, input logic [9:0] res);
        int n;
        @(posedge core_clk);
        compare_above <= cmp;
        wr(3'h0, 8'h3D);
        repeat (adc_ctrl_pkg::FIXED_REF_ACQ_CYC) @(posedge core_clk);
        wr(3'h0, 8'h3F);
        rd(3'h0);
        chk(d, 8'h3F);
        repeat (40) @(posedge core_clk);
        n = 0;
        do begin
            rd(3'h0);
            n++;
        end while (d[1] && n < 10);
        chk(n >= 3 && n <= 5, 1'b1);
        chk(d, 8'h3D);
        if (n >= 10) results();
        wr(3'h2, 8'h80);
        rd(3'h3);
        chk(d, {6'h00, res[9:8]});
        rd(3'h4);
        chk(d, res[7:0]);
        wr(3'h2, 8'h00);
        rd(3'h3);
        chk(d, res[9:2]);
        rd(3'h4);
        chk(d, {res[1:0], 6'h00});
    endtask

    task automatic t_abort();
        wr(3'h0, 8'h03);
        wr(3'h0, 8'h00);
        settle();
        chk(converter_power, 1'b0);
        chk(sample_hold, 1'b0);
        rd(3'h0);
        chk(d, 8'h00);
        // start with the converter off must be refused
        wr(3'h0, 8'h02);
        settle();
        chk(sample_hold, 1'b0);
        rd(3'h0);
        chk(d, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_refs();
        t_channels();
        t_convert(1'b1, 10'h3FF);
        t_convert(1'b0, 10'h000);
        t_abort();
        results();
    end
endmodule
